// ### cprs_cfg.svh
// constants for the command parity and rank select block
`ifndef CPRS_CFG_SVH
`define CPRS_CFG_SVH
`define CPRS_CA_W          24
`define CPRS_CW_ADDR_W     8
`define CPRS_CW_DATA_W     8
`define CPRS_CW_PARITY     8'h0E
`define CPRS_CW_MODULE     8'h0D
`define CPRS_PAR_EN_BIT    0
`define CPRS_RANK_LSB      0
`define CPRS_PARITY_RST    8'h01
`define CPRS_MODULE_RST    8'h00
`define CPRS_RANK_DIRECT2  2'h0
`define CPRS_RANK_DIRECT4  2'h1
`define CPRS_RANK_ENCODED4 2'h3
`define CPRS_ALERT_CYC     4'h2
`endif

// ### cprs_pkg.sv
// types for the command parity and rank select block
`include "cprs_cfg.svh"
package cprs_pkg;
  typedef struct packed {
    logic                       valid;
    logic                       cw_write;
    logic [1:0]                 cs_code;
    logic [`CPRS_CA_W-1:0]      ca;
    logic                       parity;
  } cprs_cmd_t;
  typedef struct packed {
    logic                       valid;
    logic [`CPRS_CW_ADDR_W-1:0] addr;
    logic [`CPRS_CW_DATA_W-1:0] data;
  } cprs_cw_t;
  typedef enum logic [1:0] {
    CPRS_DIRECT2  = 2'b00,
    CPRS_DIRECT4  = 2'b01,
    CPRS_ENCODED4 = 2'b11
  } cprs_rank_mode_t;
endpackage

// ### cprs_parity_chk.sv
// even parity check over command, address and parity bit
`timescale 1ns/1ps
`default_nettype none
module cprs_parity_chk (
  // sampled command
  input  wire logic              cmd_valid,
  input  wire logic [23:0]       ca,
  input  wire logic              parity_in,
  // result
  output logic                   mismatch
);
  always_comb begin
    mismatch = cmd_valid & (^{ca, parity_in});
  end
endmodule
`default_nettype wire

// ### cprs_top.sv
// command parity check, control word writes and rank select
//
// Summary of operation
// - control words writable by command bus or serial
// - parity control word bit enables parity checking
// - host parity compared against sampled command inputs
// - mismatch drives open-drain alert low
// - checking on: forward only parity-clean commands
// - checking off: forward every sampled command except control word writes
// - command-bus control word writes also parity checked; serial writes are not
// - each chip-select output selects one rank
// - two-bit rank mode field picks three modes
// - one or two ranks use direct two-select
// - four ranks use encoded four-select; direct four-select drives only two selects, as direct two-select does
`timescale 1ns/1ps
`include "cprs_cfg.svh"
`default_nettype none
module cprs_top (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  input  wire logic              CE,
  // command bus from host
  input  wire cprs_pkg::cprs_cmd_t CMD_IN,
  // control word write from serial management port
  input  wire cprs_pkg::cprs_cw_t  SER_CW,
  // commands to dram ranks
  output logic                   DRAM_CMD_VALID,
  output logic [`CPRS_CA_W-1:0]  DRAM_CA,
  output logic [3:0]             DRAM_CS_N,
  // open-drain alert
  output logic                   ALERT_N_O,
  output logic                   ALERT_N_OE,
  // status
  output logic                   PARITY_EN,
  output logic [1:0]             RANK_MODE,
  output logic                   PARITY_ERR_STICKY
);
  import cprs_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic                          mismatch;
  logic                          par_err;
  logic [`CPRS_CW_DATA_W-1:0]    par_cw_reg,  par_cw_next;
  logic [`CPRS_CW_DATA_W-1:0]    mod_cw_reg,  mod_cw_next;
  logic                          fwd_reg,     fwd_next;
  logic [`CPRS_CA_W-1:0]         ca_reg,      ca_next;
  logic [3:0]                    cs_n_reg,    cs_n_next;
  logic [3:0]                    alert_cnt_reg, alert_cnt_next;
  logic                          alert_oe_reg, alert_oe_next;
  logic                          sticky_reg,  sticky_next;
  logic                          bus_cw_ok;
  logic [1:0]                    mode;

  cprs_parity_chk u_chk (
    .cmd_valid (CMD_IN.valid),
    .ca        ({CMD_IN.cs_code, CMD_IN.cw_write, CMD_IN.ca[`CPRS_CA_W-4:0]}),
    .parity_in (CMD_IN.parity),
    .mismatch  (mismatch)
  );

  assign par_err = mismatch & par_cw_reg[`CPRS_PAR_EN_BIT];
  assign mode    = mod_cw_reg[`CPRS_RANK_LSB +: 2];

  ////////////////////////////////////////////////////////////////
  // control words
  always_comb begin
    par_cw_next = par_cw_reg;
    mod_cw_next = mod_cw_reg;
    bus_cw_ok   = CMD_IN.valid & CMD_IN.cw_write & ~par_err;
    if (bus_cw_ok) begin
      if (CMD_IN.ca[15:8] == `CPRS_CW_PARITY) begin
        par_cw_next = CMD_IN.ca[7:0];
      end
      if (CMD_IN.ca[15:8] == `CPRS_CW_MODULE) begin
        mod_cw_next = CMD_IN.ca[7:0];
      end
    end else if (SER_CW.valid) begin
      if (SER_CW.addr == `CPRS_CW_PARITY) begin
        par_cw_next = SER_CW.data;
      end
      if (SER_CW.addr == `CPRS_CW_MODULE) begin
        mod_cw_next = SER_CW.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // forwarding and rank select
  always_comb begin
    fwd_next  = CMD_IN.valid & ~CMD_IN.cw_write & ~par_err;
    ca_next   = CMD_IN.valid ? CMD_IN.ca : ca_reg;
    cs_n_next = 4'hF;
    if (fwd_next) begin
      unique case (mode)
        `CPRS_RANK_DIRECT2: begin
          cs_n_next = {2'h3, ~CMD_IN.cs_code};
        end
        `CPRS_RANK_DIRECT4: begin
          cs_n_next = {2'h3, ~CMD_IN.cs_code};
        end
        `CPRS_RANK_ENCODED4: begin
          cs_n_next = ~(4'h1 << CMD_IN.cs_code);
        end
        default: begin
          cs_n_next = 4'hF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // alert pulse and sticky status
  always_comb begin
    alert_cnt_next = alert_cnt_reg;
    alert_oe_next  = alert_oe_reg;
    sticky_next    = sticky_reg | par_err;
    if (par_err) begin
      alert_cnt_next = `CPRS_ALERT_CYC;
      alert_oe_next  = 1'b1;
    end else if (alert_cnt_reg > 4'h1) begin
      alert_cnt_next = alert_cnt_reg - 4'h1;
    end else begin
      alert_cnt_next = 4'h0;
      alert_oe_next  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK) begin
    if (RESET) begin
      par_cw_reg    <= `CPRS_PARITY_RST;
      mod_cw_reg    <= `CPRS_MODULE_RST;
      fwd_reg       <= 1'b0;
      ca_reg        <= '0;
      cs_n_reg      <= 4'hF;
      alert_cnt_reg <= 4'h0;
      alert_oe_reg  <= 1'b0;
      sticky_reg    <= 1'b0;
    end else if (CE) begin
      par_cw_reg    <= par_cw_next;
      mod_cw_reg    <= mod_cw_next;
      fwd_reg       <= fwd_next;
      ca_reg        <= ca_next;
      cs_n_reg      <= cs_n_next;
      alert_cnt_reg <= alert_cnt_next;
      alert_oe_reg  <= alert_oe_next;
      sticky_reg    <= sticky_next;
    end
  end

  assign DRAM_CMD_VALID    = fwd_reg;
  assign DRAM_CA           = ca_reg;
  assign DRAM_CS_N         = cs_n_reg;
  assign ALERT_N_O         = 1'b0;
  assign ALERT_N_OE        = alert_oe_reg;
  assign PARITY_EN         = par_cw_reg[`CPRS_PAR_EN_BIT];
  assign RANK_MODE         = mod_cw_reg[`CPRS_RANK_LSB +: 2];
  assign PARITY_ERR_STICKY = sticky_reg;
endmodule
`default_nettype wire

// ### cprs_top_sva.sv
// assertions for the parity and rank select block
`timescale 1ns/1ps
`default_nettype none
module cprs_top_sva (
  input wire logic                CLK,
  input wire logic                RESET,
  input wire logic                CE,
  input wire cprs_pkg::cprs_cmd_t CMD_IN,
  input wire cprs_pkg::cprs_cw_t  SER_CW,
  input wire logic                DRAM_CMD_VALID,
  input wire logic [3:0]          DRAM_CS_N,
  input wire logic                ALERT_N_OE,
  input wire logic                PARITY_EN,
  input wire logic [1:0]          RANK_MODE,
  input wire logic                PARITY_ERR_STICKY
);
  import cprs_pkg::*;
  wire logic tk = CE && CMD_IN.valid;
  wire logic bad = ^{CMD_IN.cs_code, CMD_IN.cw_write, CMD_IN.ca[20:0], CMD_IN.parity};
  wire logic err = tk && bad && PARITY_EN;
  wire logic mw = tk && CMD_IN.cw_write && !bad && CMD_IN.ca[15:8] == 8'h0D;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_err_alert: assert property (err |=> ALERT_N_OE && PARITY_ERR_STICKY)
    else $error("alert missing");
  a_err_drop: assert property (err |=> !DRAM_CMD_VALID)
    else $error("bad command forwarded");
  a_clean_fwd: assert property (tk && !CMD_IN.cw_write && !bad |=> DRAM_CMD_VALID)
    else $error("clean command lost");
  a_nochk_fwd: assert property (tk && !CMD_IN.cw_write && !PARITY_EN |=> DRAM_CMD_VALID)
    else $error("unchecked command lost");
  a_cw_drop: assert property (err && CMD_IN.cw_write && !SER_CW.valid |=> $stable(RANK_MODE))
    else $error("bad word write taken");
  a_enc_cs: assert property (DRAM_CMD_VALID && $past(RANK_MODE) == 2'h3 |-> $onehot(~DRAM_CS_N))
    else $error("encoded select not one-hot");
  a_cs_idle: assert property (!DRAM_CMD_VALID |-> DRAM_CS_N == 4'hF)
    else $error("select without command");
  a_mode_wr: assert property (mw |=> RANK_MODE == $past(CMD_IN.ca[1:0]))
    else $error("rank mode not written");
  c_err: cover property (err);
  c_enc: cover property (DRAM_CMD_VALID && RANK_MODE == 2'h3);
  c_ser: cover property (SER_CW.valid);
endmodule
bind cprs_top cprs_top_sva u_sva (.CLK(CLK), .RESET(RESET), .CE(CE), .CMD_IN(CMD_IN),
  .SER_CW(SER_CW), .DRAM_CMD_VALID(DRAM_CMD_VALID), .DRAM_CS_N(DRAM_CS_N),
  .ALERT_N_OE(ALERT_N_OE), .PARITY_EN(PARITY_EN), .RANK_MODE(RANK_MODE),
  .PARITY_ERR_STICKY(PARITY_ERR_STICKY));
`default_nettype wire

// ### cprs_host.sv
// host controller model driving the command bus
`timescale 1ns/1ps
`default_nettype none
module cprs_host (
  input  wire logic          go,
  input  wire logic          cw,
  input  wire logic          bad,
  input  wire logic [1:0]    cs,
  input  wire logic [23:0]   ca,
  output var cprs_pkg::cprs_cmd_t cmd
);
  import cprs_pkg::*;
  // idle bus shows inverted address; parity even unless flipped
  assign cmd = {go, cw, cs, go ? ca : ~ca, ^{cs, cw, ca[20:0]} ^ bad};
endmodule
`default_nettype wire

// ### cprs_top_bench.sv
// testbench for the parity and rank select block
`timescale 1ns/1ps
`default_nettype none
module cprs_top_bench;
  import cprs_pkg::*;
  logic clk = 0, rst = 1, ce = 1, go = 0, cw = 0, bad = 0, v, aoe, pe, st;
  logic [1:0] cs = 0, rm;
  logic [23:0] ca = 0, dca;
  logic [3:0] csn;
  cprs_cmd_t cmd;
  cprs_cw_t ser = '0;
  int error_cnt = 0, n_compared = 0;
  always #2 clk = ~clk;
  cprs_host host (.go(go), .cw(cw), .bad(bad), .cs(cs), .ca(ca), .cmd(cmd));
  cprs_top DUT (.CLK(clk), .RESET(rst), .CE(ce), .CMD_IN(cmd), .SER_CW(ser),
    .DRAM_CMD_VALID(v), .DRAM_CA(dca), .DRAM_CS_N(csn), .ALERT_N_O(),
    .ALERT_N_OE(aoe), .PARITY_EN(pe), .RANK_MODE(rm), .PARITY_ERR_STICKY(st));
  task chk(string n, logic [23:0] e, logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task send(logic w, logic b, logic [1:0] s, logic [23:0] a);
    @(posedge clk);
    {go, cw, bad, cs, ca} <= {1'b1, w, b, s, a};
    @(posedge clk);
    go <= 0;
    #1;
  endtask
  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    #1;
    chk("par_en", 24'h1, 24'(pe));
    send(0, 0, 2'h1, 24'h123456);
    chk("fwd", 24'h1, 24'(v));
    chk("ca", 24'h123456, dca);
    chk("cs_dir2", 24'hE, 24'(csn));
    send(0, 1, 2'h1, 24'h0000F0);
    chk("drop", 24'h0, 24'(v));
    chk("alert", 24'h1, 24'({aoe, st} == 2'h3));
    send(1, 1, 2'h0, 24'h000D03);
    chk("cw_drop", 24'h0, 24'(rm));
    repeat (2) @(posedge clk);
    #1;
    chk("alert_end", 24'h0, 24'(aoe));
    $display("parity test done");
    @(posedge clk);
    ser <= {1'b1, 8'h0E, 8'h00};
    @(posedge clk);
    ser <= '0;
    #1;
    chk("par_off", 24'h0, 24'(pe));
    send(0, 1, 2'h2, 24'h000F0F);
    chk("nochk", 24'h1, 24'(v));
    for (int m = 0; m < 4; m++) begin
      send(1, 0, 2'h0, {16'h000D, 6'h0, m[1:0]});
      chk("mode", {22'h0, m[1:0]}, 24'(rm));
      send(0, 0, 2'h2, 24'h000100);
      if (m == 3) chk("cs_enc", 24'hB, 24'(csn));
      if (m == 2) chk("cs_none", 24'hF, 24'(csn));
      if (m < 2) chk("cs_dir", 24'hD, 24'(csn));
    end
    $display("rank test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
